/* rtl/pmts_pkg.sv */
package pmts_pkg;

  // ***************************************************************
  // linear-format exponents (5-bit two's complement)
  // ***************************************************************
  localparam logic [4:0] EXP_VIN  = 5'h1D;  // -3
  localparam logic [4:0] EXP_IOUT = 5'h1C;  // -4
  localparam logic [4:0] EXP_TEMP = 5'h1E;  // -2

  // ***************************************************************
  // command codes of the read port
  // ***************************************************************
  localparam logic [7:0] CMD_VIN_RD      = 8'h10;
  localparam logic [7:0] CMD_VIN_OFF     = 8'h11;
  localparam logic [7:0] CMD_VIN_GAIN    = 8'h12;
  localparam logic [7:0] CMD_IOUT_RD     = 8'h13;
  localparam logic [7:0] CMD_IOUT_OFF    = 8'h14;
  localparam logic [7:0] CMD_IOUT_GAIN   = 8'h15;
  localparam logic [7:0] CMD_TEMP_RD     = 8'h16;
  localparam logic [7:0] CMD_SUMMARY     = 8'h17;
  localparam logic [7:0] CMD_VOUT_FLT    = 8'h18;
  localparam logic [7:0] CMD_IOUT_FLT    = 8'h19;
  localparam logic [7:0] CMD_INPUT_FLT   = 8'h1A;
  localparam logic [7:0] CMD_THERM_FLT   = 8'h1B;
  localparam logic [7:0] CMD_COMM_FLT    = 8'h1C;

  // ***************************************************************
  // field positions of the summary word and status bytes
  // ***************************************************************
  localparam int SUM_VOUT   = 15;
  localparam int SUM_IOUT   = 14;
  localparam int SUM_INPUT  = 13;
  localparam int SUM_PGOOD  = 11;
  localparam int SUM_OFF    = 6;
  localparam int SUM_VOV    = 5;
  localparam int SUM_IOC    = 4;
  localparam int SUM_VUV    = 3;
  localparam int SUM_TEMP   = 2;
  localparam int SUM_COMM   = 1;
  localparam int ST_FAULT   = 7;
  localparam int ST_OC_WARN = 5;
  localparam int ST_VIN_UV  = 4;
  localparam int ST_LOW_OFF = 3;
  localparam int ST_HOT_WARN = 6;
  localparam int ST_BAD_DAT = 6;
  localparam int ST_PEC     = 5;

  // ***************************************************************
  // reset values, scaling and counts
  // ***************************************************************
  localparam logic [7:0]  STATUS_RST  = 8'h00;
  localparam logic [15:0] WORD_RST    = 16'h0000;
  localparam int GAIN_SHIFT   = 13;     // gain word / 8192
  localparam int IOUT_BLANK_MA = 1650;  // blank threshold, mA
  localparam int IOUT_STEP_UA  = 62500; // mantissa step, uA
  localparam int IOUT_BLANK_LSB =
    (IOUT_BLANK_MA * 1000 + IOUT_STEP_UA - 1) / IOUT_STEP_UA;
  localparam int AVG_SHIFT    = 3;      // average over ~8 samples
  localparam int MANT_MAX     = 1023;   // positive-only mantissa
  localparam int TEMP_REF     = 100;    // 25 C in 0.25 C steps
  localparam int TC_NUM       = 1;      // current tempco numerator
  localparam int TC_SHIFT     = 12;

  // ***************************************************************
  // carriers
  // ***************************************************************
  typedef struct packed {
    logic [15:0] vin_off;
    logic [15:0] vin_gain;
    logic [15:0] iout_off;
    logic [15:0] iout_gain;
  } pmts_cal_t;

  typedef struct packed {
    logic vout_ov;
    logic iout_oc;
    logic iout_oc_warn;
    logic vin_ov;
    logic vin_uv;
    logic vin_low_off;
    logic overtemperature;
    logic overtemperature_warn;
    logic output_off;
    logic pgood_n;
  } pmts_cond_t;

  typedef struct packed {
    logic bad_cmd;
    logic bad_data;
    logic pec_fail;
    logic comm_memory_fault;
  } pmts_comm_t;

  typedef struct packed {
    logic [15:0] vin_rd;
    logic [15:0] iout_acc;
    logic [15:0] iout_rd;
    logic [15:0] temp_rd;
    logic [7:0]  vout_flt;
    logic [7:0]  iout_flt;
    logic [7:0]  input_flt;
    logic [7:0]  therm_flt;
    logic [7:0]  comm_flt;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        rd_unsup;
  } pmts_state_t;

endpackage

/* rtl/pmts_telemetry.sv */
`timescale 1ns/1ps
// Summary of operation
// - input voltage: exponent -3, mantissa top bit zero
// - input offset word: exponent -3, 125mV step
// - input voltage = raw*gain/8192 + offset
// - output current: exponent -4, non-negative mantissa
// - blank output current below 1.65A
// - current offset exponent -4; raw*gain/8192 + offset
// - output current reading is averaged
// - sinking current reads as zero
// - output current corrected for module temperature
// - temperature word: exponent -2, signed mantissa
// - summary high byte bits 15,14,13,11
// - summary low byte bits 6 down to 1
// - unsupported status bits zero, all reset zero except live summary bits 11, 6, 1
// - output voltage byte: only bit 7 overvoltage
// - output current byte: fault 7, warning 5
// - input byte: overvoltage 7, undervoltage 4, off 3
// - temperature byte: fault 7, warning 6
// - comm byte: command 7, data 6, PEC 5
// - value equals mantissa times two to exponent
module pmts_telemetry (
  // clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 nrst_i,
  // converter samples, one-cycle strobe each
  input  wire logic                 vin_smp_i,
  input  wire logic [10:0]          vin_raw_i,
  input  wire logic                 iout_smp_i,
  input  wire logic signed [11:0]   iout_raw_i,
  input  wire logic                 temp_smp_i,
  input  wire logic signed [10:0]   temp_raw_i,
  // factory calibration words from non-volatile store
  input  wire pmts_pkg::pmts_cal_t  cal_i,
  // protection conditions, levels
  input  wire pmts_pkg::pmts_cond_t cond_i,
  // communication fault events, one-cycle pulses
  input  wire pmts_pkg::pmts_comm_t comm_evt_i,
  input  wire logic                 clear_faults_i,
  // command read port
  input  wire logic                 rd_req_i,
  input  wire logic [7:0]           rd_cmd_i,
  output logic                      rd_valid_o,
  output logic [15:0]               rd_data_o,
  output logic                      rd_unsup_o
);

  // ***************************************************************
  // reset release
  // ***************************************************************
  logic rst_meta_r;
  logic rst_sync_n_r;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_r   <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_meta_r   <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  // ***************************************************************
  // state
  // ***************************************************************
  pmts_pkg::pmts_state_t st_r;
  pmts_pkg::pmts_state_t st_nxt;

  logic signed [31:0] vin_scaled;
  logic signed [31:0] iout_scaled;
  logic signed [31:0] iout_tc;
  logic signed [31:0] temp_delta;
  logic        [31:0] iout_avg;
  logic        [15:0] summary;
  logic        [7:0]  vout_set;
  logic        [7:0]  iout_set;
  logic        [7:0]  input_set;
  logic        [7:0]  therm_set;
  logic        [7:0]  comm_set;
  logic               unsup_cmd;

  // clamp a corrected value into the positive-only 10-bit mantissa
  function automatic logic [9:0] clamp_pos(input logic signed [31:0] v);
    logic [9:0] r;
    if (v < 0) begin
      r = 10'h000;
    end else if (v > pmts_pkg::MANT_MAX) begin
      r = 10'h3FF;
    end else begin
      r = v[9:0];
    end
    return r;
  endfunction

  always_comb begin
    st_nxt = st_r;

    // *************************************************************
    // input voltage
    // *************************************************************
    vin_scaled = ($signed({21'h00000, vin_raw_i})
                  * $signed({16'h0000, cal_i.vin_gain}))
                 >>> pmts_pkg::GAIN_SHIFT;
    vin_scaled = vin_scaled
                 + {{21{cal_i.vin_off[10]}}, cal_i.vin_off[10:0]};
    if (vin_smp_i) begin
      st_nxt.vin_rd = {pmts_pkg::EXP_VIN, 1'b0,
                       clamp_pos(vin_scaled)};
    end

    // *************************************************************
    // output current: scale, average, temperature correction
    // *************************************************************
    // a negative raw sample means the converter sinks current
    if (iout_raw_i[11]) begin
      iout_scaled = 32'sh00000000;
    end else begin
      iout_scaled = ($signed({20'h00000, iout_raw_i})
                     * $signed({16'h0000, cal_i.iout_gain}))
                    >>> pmts_pkg::GAIN_SHIFT;
      iout_scaled = iout_scaled
                    + {{21{cal_i.iout_off[10]}}, cal_i.iout_off[10:0]};
    end
    if (iout_scaled < 0) begin
      iout_scaled = 32'sh00000000;
    end else if (iout_scaled > 32'sh000007FF) begin
      iout_scaled = 32'sh000007FF;
    end
    // accumulator holds eight times the running mean
    iout_avg = {16'h0000, st_r.iout_acc} >> pmts_pkg::AVG_SHIFT;
    if (iout_smp_i) begin
      st_nxt.iout_acc = 16'(32'(st_r.iout_acc) - iout_avg
                            + 32'(iout_scaled));
    end
    // tempco applied after averaging so noise is not amplified
    temp_delta = $signed({{21{st_r.temp_rd[10]}}, st_r.temp_rd[10:0]})
                 - pmts_pkg::TEMP_REF;
    iout_tc = $signed(iout_avg)
              + (($signed(iout_avg) * temp_delta * pmts_pkg::TC_NUM)
                 >>> pmts_pkg::TC_SHIFT);
    if (iout_smp_i) begin
      if (iout_tc < pmts_pkg::IOUT_BLANK_LSB) begin
        st_nxt.iout_rd = {pmts_pkg::EXP_IOUT, 11'h000};
      end else begin
        st_nxt.iout_rd = {pmts_pkg::EXP_IOUT, 1'b0,
                          clamp_pos(iout_tc)};
      end
    end

    // *************************************************************
    // temperature
    // *************************************************************
    if (temp_smp_i) begin
      st_nxt.temp_rd = {pmts_pkg::EXP_TEMP, temp_raw_i};
    end

    // *************************************************************
    // status bytes; set wins over clear-faults
    // *************************************************************
    unsup_cmd = 1'b0;
    case (rd_cmd_i)
      pmts_pkg::CMD_VIN_RD,    pmts_pkg::CMD_VIN_OFF,
      pmts_pkg::CMD_VIN_GAIN,  pmts_pkg::CMD_IOUT_RD,
      pmts_pkg::CMD_IOUT_OFF,  pmts_pkg::CMD_IOUT_GAIN,
      pmts_pkg::CMD_TEMP_RD,   pmts_pkg::CMD_SUMMARY,
      pmts_pkg::CMD_VOUT_FLT,  pmts_pkg::CMD_IOUT_FLT,
      pmts_pkg::CMD_INPUT_FLT, pmts_pkg::CMD_THERM_FLT,
      pmts_pkg::CMD_COMM_FLT: unsup_cmd = 1'b0;
      default:                unsup_cmd = rd_req_i;
    endcase

    vout_set  = 8'h00;
    iout_set  = 8'h00;
    input_set = 8'h00;
    therm_set = 8'h00;
    comm_set  = 8'h00;
    vout_set[pmts_pkg::ST_FAULT]    = cond_i.vout_ov;
    iout_set[pmts_pkg::ST_FAULT]    = cond_i.iout_oc;
    iout_set[pmts_pkg::ST_OC_WARN]  = cond_i.iout_oc_warn;
    input_set[pmts_pkg::ST_FAULT]   = cond_i.vin_ov;
    input_set[pmts_pkg::ST_VIN_UV]  = cond_i.vin_uv;
    input_set[pmts_pkg::ST_LOW_OFF] = cond_i.vin_low_off;
    therm_set[pmts_pkg::ST_FAULT]   = cond_i.overtemperature;
    therm_set[pmts_pkg::ST_HOT_WARN] = cond_i.overtemperature_warn;
    comm_set[pmts_pkg::ST_FAULT]    = comm_evt_i.bad_cmd
                                      | unsup_cmd;
    comm_set[pmts_pkg::ST_BAD_DAT]  = comm_evt_i.bad_data;
    comm_set[pmts_pkg::ST_PEC]      = comm_evt_i.pec_fail;

    // latched until clear-faults; a condition still present re-sets
    if (clear_faults_i) begin
      st_nxt.vout_flt  = vout_set;
      st_nxt.iout_flt  = iout_set;
      st_nxt.input_flt = input_set;
      st_nxt.therm_flt = therm_set;
      st_nxt.comm_flt  = comm_set;
    end else begin
      st_nxt.vout_flt  = st_r.vout_flt  | vout_set;
      st_nxt.iout_flt  = st_r.iout_flt  | iout_set;
      st_nxt.input_flt = st_r.input_flt | input_set;
      st_nxt.therm_flt = st_r.therm_flt | therm_set;
      st_nxt.comm_flt  = st_r.comm_flt  | comm_set;
    end

    // *************************************************************
    // summary word from the latched category bytes, plus live power-good, output-off and memory-fault inputs
    // *************************************************************
    summary = pmts_pkg::WORD_RST;
    summary[pmts_pkg::SUM_VOUT]  = |st_r.vout_flt;
    summary[pmts_pkg::SUM_IOUT]  = |st_r.iout_flt;
    summary[pmts_pkg::SUM_INPUT] = |st_r.input_flt;
    summary[pmts_pkg::SUM_PGOOD] = cond_i.pgood_n;
    summary[pmts_pkg::SUM_OFF]   = cond_i.output_off;
    summary[pmts_pkg::SUM_VOV]   = st_r.vout_flt[pmts_pkg::ST_FAULT];
    summary[pmts_pkg::SUM_IOC]   = st_r.iout_flt[pmts_pkg::ST_FAULT];
    summary[pmts_pkg::SUM_VUV]   = st_r.input_flt[pmts_pkg::ST_VIN_UV];
    summary[pmts_pkg::SUM_TEMP]  = |st_r.therm_flt;
    summary[pmts_pkg::SUM_COMM]  = (|st_r.comm_flt)
                                   | comm_evt_i.comm_memory_fault;

    // *************************************************************
    // read port: answer one cycle after the request
    // *************************************************************
    st_nxt.rd_valid = rd_req_i;
    st_nxt.rd_unsup = unsup_cmd;
    if (rd_req_i) begin
      case (rd_cmd_i)
        pmts_pkg::CMD_VIN_RD:    st_nxt.rd_data = st_r.vin_rd;
        pmts_pkg::CMD_VIN_OFF:   st_nxt.rd_data =
          {pmts_pkg::EXP_VIN, cal_i.vin_off[10:0]};
        pmts_pkg::CMD_VIN_GAIN:  st_nxt.rd_data = cal_i.vin_gain;
        pmts_pkg::CMD_IOUT_RD:   st_nxt.rd_data = st_r.iout_rd;
        pmts_pkg::CMD_IOUT_OFF:  st_nxt.rd_data =
          {pmts_pkg::EXP_IOUT, cal_i.iout_off[10:0]};
        pmts_pkg::CMD_IOUT_GAIN: st_nxt.rd_data = cal_i.iout_gain;
        pmts_pkg::CMD_TEMP_RD:   st_nxt.rd_data = st_r.temp_rd;
        pmts_pkg::CMD_SUMMARY:   st_nxt.rd_data = summary;
        pmts_pkg::CMD_VOUT_FLT:  st_nxt.rd_data = {8'h00, st_r.vout_flt};
        pmts_pkg::CMD_IOUT_FLT:  st_nxt.rd_data = {8'h00, st_r.iout_flt};
        pmts_pkg::CMD_INPUT_FLT: st_nxt.rd_data = {8'h00, st_r.input_flt};
        pmts_pkg::CMD_THERM_FLT: st_nxt.rd_data = {8'h00, st_r.therm_flt};
        pmts_pkg::CMD_COMM_FLT:  st_nxt.rd_data = {8'h00, st_r.comm_flt};
        default:                 st_nxt.rd_data = pmts_pkg::WORD_RST;
      endcase
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      st_r           <= '0;
      st_r.vin_rd    <= {pmts_pkg::EXP_VIN, 11'h000};
      st_r.iout_rd   <= {pmts_pkg::EXP_IOUT, 11'h000};
      st_r.temp_rd   <= {pmts_pkg::EXP_TEMP, 11'h000};
      st_r.vout_flt  <= pmts_pkg::STATUS_RST;
      st_r.iout_flt  <= pmts_pkg::STATUS_RST;
      st_r.input_flt <= pmts_pkg::STATUS_RST;
      st_r.therm_flt <= pmts_pkg::STATUS_RST;
      st_r.comm_flt  <= pmts_pkg::STATUS_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_valid_o = st_r.rd_valid;
  assign rd_data_o  = st_r.rd_data;
  assign rd_unsup_o = st_r.rd_unsup;

endmodule

/* verification/pmts_telemetry_properties.sv */
`timescale 1ns/1ps
module pmts_telemetry_properties (
  // clock and reset
  input wire logic                 clk_sys_i,
  input wire logic                 nrst_i,
  // samples
  input wire logic                 vin_smp_i,
  input wire logic [10:0]          vin_raw_i,
  input wire logic                 iout_smp_i,
  input wire logic signed [11:0]   iout_raw_i,
  input wire logic                 temp_smp_i,
  input wire logic signed [10:0]   temp_raw_i,
  // calibration, conditions, events
  input wire pmts_pkg::pmts_cal_t  cal_i,
  input wire pmts_pkg::pmts_cond_t cond_i,
  input wire pmts_pkg::pmts_comm_t comm_evt_i,
  input wire logic                 clear_faults_i,
  // read port
  input wire logic                 rd_req_i,
  input wire logic [7:0]           rd_cmd_i,
  input wire logic                 rd_valid_o,
  input wire logic [15:0]          rd_data_o,
  input wire logic                 rd_unsup_o
);
  // ***************************************************************
  // read port checks
  // ***************************************************************
  logic [7:0] c;
  logic       q;
  assign c = rd_cmd_i;
  assign q = rd_req_i;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);

  a_vin_format: assert property (q && c == pmts_pkg::CMD_VIN_RD |=>
      rd_data_o[15:11] == pmts_pkg::EXP_VIN && !rd_data_o[10])
    else $error("input voltage word malformed");
  a_vin_offset: assert property (q && c == pmts_pkg::CMD_VIN_OFF |=>
      rd_data_o[15:11] == pmts_pkg::EXP_VIN)
    else $error("input offset exponent wrong");
  a_gain_word: assert property (q && c == pmts_pkg::CMD_VIN_GAIN |=>
      rd_data_o == $past(cal_i.vin_gain))
    else $error("input gain word not returned");
  a_iout_format: assert property (q && c == pmts_pkg::CMD_IOUT_RD |=>
      rd_data_o[15:11] == pmts_pkg::EXP_IOUT && !rd_data_o[10])
    else $error("output current word malformed");
  a_temp_format: assert property (q && c == pmts_pkg::CMD_TEMP_RD |=>
      rd_data_o[15:11] == pmts_pkg::EXP_TEMP)
    else $error("temperature exponent wrong");
  a_byte_upper: assert property (q && c >= pmts_pkg::CMD_VOUT_FLT &&
      c <= pmts_pkg::CMD_COMM_FLT |=> rd_data_o[15:8] == 8'h00)
    else $error("status byte upper half not zero");
  a_sum_unused: assert property (q && c == pmts_pkg::CMD_SUMMARY |=>
      (rd_data_o & 16'h1781) == 16'h0000)
    else $error("unsupported summary bit set");
  a_pgood_live: assert property (q && c == pmts_pkg::CMD_SUMMARY &&
      cond_i.pgood_n |=> rd_data_o[11])
    else $error("power-good negation not shown");
  a_vout_latch: assert property (cond_i.vout_ov ##1
      !clear_faults_i ##1 q && c == pmts_pkg::CMD_VOUT_FLT |=>
      rd_data_o[7] && rd_data_o[6:0] == 7'h00)
    else $error("output voltage fault not latched");
  a_unknown_cmd: assert property (q && (c < pmts_pkg::CMD_VIN_RD ||
      c > pmts_pkg::CMD_COMM_FLT) |=> rd_unsup_o && rd_data_o == 16'h0000)
    else $error("unknown code not refused");
endmodule

bind pmts_telemetry pmts_telemetry_properties pmts_telemetry_properties_inst (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .vin_smp_i(vin_smp_i),
  .vin_raw_i(vin_raw_i), .iout_smp_i(iout_smp_i), .iout_raw_i(iout_raw_i),
  .temp_smp_i(temp_smp_i), .temp_raw_i(temp_raw_i), .cal_i(cal_i),
  .cond_i(cond_i), .comm_evt_i(comm_evt_i), .clear_faults_i(clear_faults_i),
  .rd_req_i(rd_req_i), .rd_cmd_i(rd_cmd_i), .rd_valid_o(rd_valid_o),
  .rd_data_o(rd_data_o), .rd_unsup_o(rd_unsup_o));

/* verification/pmts_host.sv */
`timescale 1ns/1ps
module pmts_host (
  // clock
  input  wire logic        clk_sys_i,
  // answer from the device
  input  wire logic        rd_valid_i,
  input  wire logic [15:0] rd_data_i,
  input  wire logic        rd_unsup_i,
  // request to the device
  output logic             rd_req_o,
  output logic [7:0]       rd_cmd_o
);
  // ***************************************************************
  // host read sequencer
  // ***************************************************************
  initial begin
    rd_req_o = 1'b0;
    rd_cmd_o = 8'h00;
  end

  // code line shows the inverse once released, so a stale code is
  // never mistaken for a live one
  task automatic read(input logic [7:0] cmd, output logic [15:0] data,
                      output logic unsup, output logic ok);
    int n;
    n = 0;
    @(negedge clk_sys_i);
    rd_req_o = 1'b1;
    rd_cmd_o = cmd;
    @(negedge clk_sys_i);
    rd_req_o = 1'b0;
    rd_cmd_o = ~cmd;
    while (rd_valid_i !== 1'b1 && n < 4) begin
      @(negedge clk_sys_i);
      n++;
    end
    ok = rd_valid_i;
    data = rd_data_i;
    unsup = rd_unsup_i;
  endtask
endmodule

/* verification/test_pmts_telemetry.sv */
`timescale 1ns/1ps
module test_pmts_telemetry;
  // ***************************************************************
  // stimulus and checking
  // ***************************************************************
  logic                 clk_sys, nrst, vin_smp, iout_smp, temp_smp, clr;
  logic [10:0]          vin_raw, m0;
  logic signed [11:0]   iout_raw;
  logic signed [10:0]   temp_raw;
  pmts_pkg::pmts_cal_t  cal;
  pmts_pkg::pmts_cond_t cnd;
  pmts_pkg::pmts_comm_t cev;
  logic                 rd_req, rd_valid, rd_unsup;
  logic [7:0]           rd_cmd;
  logic [15:0]          rd_data, rdat;
  int                   n_errors, cmp_count;

  always #2 clk_sys = ~clk_sys;

  pmts_telemetry pmts_telemetry_inst (
    .clk_sys_i(clk_sys), .nrst_i(nrst), .vin_smp_i(vin_smp),
    .vin_raw_i(vin_raw), .iout_smp_i(iout_smp), .iout_raw_i(iout_raw),
    .temp_smp_i(temp_smp), .temp_raw_i(temp_raw), .cal_i(cal),
    .cond_i(cnd), .comm_evt_i(cev), .clear_faults_i(clr),
    .rd_req_i(rd_req), .rd_cmd_i(rd_cmd), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .rd_unsup_o(rd_unsup));
  pmts_host pmts_host_inst (
    .clk_sys_i(clk_sys), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
    .rd_unsup_i(rd_unsup), .rd_req_o(rd_req), .rd_cmd_o(rd_cmd));

  function automatic logic [15:0] lin(logic [4:0] e, logic [10:0] m);
    return {e, m};
  endfunction

  task automatic stop_test();
    $display("errors %0d, comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic get(input logic [7:0] cm, output logic u);
    logic ok;
    pmts_host_inst.read(cm, rdat, u, ok);
    if (ok !== 1'b1) begin
      n_errors++;
      $display("wrong value at %0t: read not answered", $time);
      stop_test();
    end
  endtask

  task automatic rd(input logic [7:0] cm, input logic [15:0] e,
                    input logic u = 1'b0);
    logic uu;
    get(cm, uu);
    check(rdat, e);
    check({15'h0000, uu}, {15'h0000, u});
  endtask

  // averaging leaves a small truncation error, so currents get a window
  task automatic rng(input logic [10:0] lo, input logic [10:0] hi);
    logic uu;
    get(pmts_pkg::CMD_IOUT_RD, uu);
    check({11'h000, rdat[15:11]}, {11'h000, pmts_pkg::EXP_IOUT});
    check({15'h0000, rdat[10:0] >= lo && rdat[10:0] <= hi}, 16'h0001);
  endtask

  task automatic smp(input int k, input logic [11:0] v, input int n);
    @(negedge clk_sys);
    {vin_smp, iout_smp, temp_smp} = {k == 0, k == 1, k == 2};
    {vin_raw, iout_raw, temp_raw} = {v[10:0], v, v[10:0]};
    repeat (n) @(negedge clk_sys);
    {vin_smp, iout_smp, temp_smp} = 3'b000;
    {vin_raw, iout_raw, temp_raw} = ~{v[10:0], v, v[10:0]};
  endtask

  task automatic clear();
    @(negedge clk_sys);
    clr = 1'b1;
    @(negedge clk_sys);
    clr = 1'b0;
  endtask

  task automatic flt(input logic [9:0] cn, input logic [3:0] ce,
                     input logic [7:0] cm, input logic [15:0] b, s);
    @(negedge clk_sys);
    {cnd, cev} = {cn, ce};
    @(negedge clk_sys);
    {cnd, cev} = 14'h0000;
    rd(cm, b);
    rd(pmts_pkg::CMD_SUMMARY, s);
    clear();
    rd(cm, 16'h0000);
  endtask

  initial begin
    {clk_sys, nrst, vin_smp, iout_smp, temp_smp, clr} = 6'h00;
    {vin_raw, iout_raw, temp_raw, cnd, cev} = 48'h0;
    cal = {16'hEFFC, 16'h4000, 16'hE000, 16'h3000};
    n_errors = 0;
    cmp_count = 0;
    repeat (8) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (3) @(negedge clk_sys);
    for (int c = 8'h17; c <= 8'h1C; c++) begin
      rd(8'(c), 16'h0000);
    end
    rd(pmts_pkg::CMD_VIN_RD, 16'hE800);
    rd(pmts_pkg::CMD_TEMP_RD, 16'hF000);
    rd(pmts_pkg::CMD_VIN_OFF, 16'hEFFC);
    rd(pmts_pkg::CMD_VIN_GAIN, 16'h4000);
    rd(pmts_pkg::CMD_IOUT_OFF, 16'hE000);
    rd(pmts_pkg::CMD_IOUT_GAIN, 16'h3000);
    smp(2, 12'h7EC, 1);
    rd(pmts_pkg::CMD_TEMP_RD, lin(pmts_pkg::EXP_TEMP, 11'h7EC));
    smp(2, 12'h064, 1);
    smp(0, 12'h064, 1);
    rd(pmts_pkg::CMD_VIN_RD, lin(pmts_pkg::EXP_VIN, 11'h0C4));
    smp(0, 12'h7D0, 1);
    rd(pmts_pkg::CMD_VIN_RD, lin(pmts_pkg::EXP_VIN, 11'h3FF));
    smp(1, 12'h0A0, 64);
    rng(11'h0E7, 11'h0F1);
    m0 = rdat[10:0];
    smp(1, 12'hFCE, 64);
    rd(pmts_pkg::CMD_IOUT_RD, 16'hE000);
    smp(1, 12'h190, 1);
    rng(11'h000, 11'h064);
    smp(1, 12'h011, 64);
    rd(pmts_pkg::CMD_IOUT_RD, 16'hE000);
    smp(1, 12'h0A0, 64);
    smp(2, 12'h1F4, 1);
    smp(1, 12'h0A0, 16);
    rng(m0 + 11'h00A, 11'h190);
    flt(10'h200, 4'h0, pmts_pkg::CMD_VOUT_FLT, 16'h0080, 16'h8020);
    flt(10'h100, 4'h0, pmts_pkg::CMD_IOUT_FLT, 16'h0080, 16'h4010);
    flt(10'h080, 4'h0, pmts_pkg::CMD_IOUT_FLT, 16'h0020, 16'h4000);
    flt(10'h40, 4'h0, pmts_pkg::CMD_INPUT_FLT, 16'h0080, 16'h2000);
    flt(10'h20, 4'h0, pmts_pkg::CMD_INPUT_FLT, 16'h0010, 16'h2008);
    flt(10'h10, 4'h0, pmts_pkg::CMD_INPUT_FLT, 16'h0008, 16'h2000);
    flt(10'h08, 4'h0, pmts_pkg::CMD_THERM_FLT, 16'h0080, 16'h0004);
    flt(10'h04, 4'h0, pmts_pkg::CMD_THERM_FLT, 16'h0040, 16'h0004);
    flt(10'h000, 4'h8, pmts_pkg::CMD_COMM_FLT, 16'h0080, 16'h0002);
    flt(10'h000, 4'h4, pmts_pkg::CMD_COMM_FLT, 16'h0040, 16'h0002);
    flt(10'h000, 4'h2, pmts_pkg::CMD_COMM_FLT, 16'h0020, 16'h0002);
    @(negedge clk_sys);
    cnd = 10'h200;
    clear();
    cnd = 10'h000;
    rd(pmts_pkg::CMD_VOUT_FLT, 16'h0080);
    clear();
    cnd = 10'h002;
    rd(pmts_pkg::CMD_SUMMARY, 16'h0040);
    cnd = 10'h001;
    rd(pmts_pkg::CMD_SUMMARY, 16'h0800);
    {cnd, cev} = 14'h0001;
    rd(pmts_pkg::CMD_SUMMARY, 16'h0002);
    cev = 4'h0;
    rd(pmts_pkg::CMD_SUMMARY, 16'h0000);
    rd(8'h0F, 16'h0000, 1'b1);
    rd(8'h1D, 16'h0000, 1'b1);
    rd(pmts_pkg::CMD_COMM_FLT, 16'h0080);
    nrst = 1'b0;
    repeat (2) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (3) @(negedge clk_sys);
    rd(pmts_pkg::CMD_COMM_FLT, 16'h0000);
    stop_test();
  end
endmodule
